/* File: rtl/nvp_ctrl.sv */
// nvm page program controller with page buffer and wishbone registers
//
// The placing of the registers and the Wishbone register port are this design's own decisions.

////////////////////////////////////////////////////////////////////////////////
module nvp_ctrl
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [3:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	// cpu memory port: stores fill buffer, loads read arrays
	input  wire logic               mem_req_i,
	input  wire logic               mem_we_i,
	input  wire logic [1:0]         mem_region_i,
	input  wire logic [15:0]        mem_addr_i,
	input  wire logic [7:0]         mem_wdata_i,
	input  wire logic [7:0]         mem_arr_rdata_i,
	output logic      [7:0]         mem_rdata_o,
	output logic                    mem_ack_o,
	// executing section of the fetch address and fetch gate
	input  wire logic [15:0]        fetch_addr_i,
	input  wire logic               from_debug_i,
	output logic                    fetch_block_o,
	output logic                    cpu_halt_o,
	// fuses, sampled only on reset, and the wake input
	input  wire logic [7:0]         loader_section_end_fuse_i,
	input  wire logic [7:0]         code_section_end_fuse_i,
	input  wire logic               eeprom_keep_fuse_i,
	input  wire logic               wake_i,
	// array operation
	output nvp_pkg::nvp_op_s        op_o,
	output logic      [7:0]         pb_rdata_o,
	output logic                    pb_mark_o,
	input  wire logic [5:0]         pb_raddr_i,
	output logic                    fuse_wr_o
);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0]               pb_q [nvp_pkg::PB_BYTES];
	logic [nvp_pkg::PB_BYTES-1:0] mark_q;
	logic [7:0]               boot_end_q;
	logic [7:0]               code_end_q;
	logic                     keep_q;
	logic                     wp_q;
	logic                     lock_q;
	logic                     err_q;
	logic                     flash_busy_flag_q;
	logic                     eeprom_busy_flag_q;
	logic [1:0]               pb_region_q;
	logic                     pb_mixed_q;
	logic [15:0]              addr_q;
	logic [7:0]               cnt_q;
	nvp_pkg::nvp_state_e      state_q;
	nvp_pkg::nvp_cmd_e        cmd_q;
	logic                     clear_pb;

	// section of a flash address
	// section granules
	function automatic nvp_pkg::nvp_sec_e sec_of(input logic [15:0] a);
		logic [7:0] g;
		g = a[15:nvp_pkg::GRAN_SHIFT];
		if (boot_end_q == 8'h00)
			sec_of = nvp_pkg::SEC_LOADER;
		else if (g < boot_end_q)
			sec_of = nvp_pkg::SEC_LOADER;
		else if (code_end_q == 8'h00 || g < code_end_q)
			sec_of = nvp_pkg::SEC_CODE;
		else
			sec_of = nvp_pkg::SEC_DATA;
	endfunction

	// the function reads the fuse copies; a comb process follows them, a wire would not
	nvp_pkg::nvp_sec_e exec_sec;
	nvp_pkg::nvp_sec_e tgt_sec;
	always_comb
	begin
		exec_sec = sec_of(fetch_addr_i);
		tgt_sec  = sec_of(addr_q);
	end
	wire logic              busy     = flash_busy_flag_q | eeprom_busy_flag_q;
	wire logic              wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic              cmd_wr   = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == nvp_pkg::OFS_CTRLA);
	wire nvp_pkg::nvp_cmd_e new_cmd  = nvp_pkg::nvp_cmd_e'(wb_dat_i[2:0]);
	wire logic              is_flash = (pb_region_q == nvp_pkg::REG_FLASH);

	// protection check for a page command
	// directional protection
	logic prot_bad;
	always_comb
	begin
		prot_bad = 1'b0;
		if (!from_debug_i)
		begin
			if (exec_sec == nvp_pkg::SEC_DATA)
				prot_bad = 1'b1;
			else if (is_flash)
			begin
				if (tgt_sec == nvp_pkg::SEC_LOADER)
					prot_bad = 1'b1;
				else if (tgt_sec == nvp_pkg::SEC_CODE && (exec_sec != nvp_pkg::SEC_LOADER || wp_q))
					prot_bad = 1'b1;
			end
		end
		if (pb_mixed_q)
			prot_bad = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// fuses captured at reset release; new fuse values need a reset
	// fuse after reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			boot_end_q <= loader_section_end_fuse_i;
			code_end_q <= code_section_end_fuse_i;
			keep_q     <= eeprom_keep_fuse_i;
		end
	end

	// wishbone register access; ack one cycle after request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			wp_q     <= 1'b0;
			lock_q   <= 1'b0;
			addr_q   <= 16'h0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i)
			begin
				if (wb_adr_i == nvp_pkg::OFS_CTRLA)
					wb_dat_o <= {29'h0, cmd_q};
				else if (wb_adr_i == nvp_pkg::OFS_CTRLB)
					wb_dat_o <= {30'h0, lock_q, wp_q};
				else if (wb_adr_i == nvp_pkg::OFS_STATUS)
					wb_dat_o <= {29'h0, err_q, eeprom_busy_flag_q, flash_busy_flag_q};
				else if (wb_adr_i == nvp_pkg::OFS_ADDR)
					wb_dat_o <= {16'h0, addr_q};
			end
			if (wb_req && wb_we_i)
			begin
				if (wb_adr_i == nvp_pkg::OFS_CTRLB && wb_sel_i[0])
				begin
					wp_q <= wp_q | wb_dat_i[nvp_pkg::CTRLB_WP_BIT];
					if (exec_sec == nvp_pkg::SEC_LOADER)
						lock_q <= lock_q | wb_dat_i[nvp_pkg::CTRLB_LOCK_BIT];
				end
				else if (wb_adr_i == nvp_pkg::OFS_ADDR && from_debug_i)
					addr_q <= wb_dat_i[15:0];
			end
			if (mem_req_i && mem_we_i && !busy)
				addr_q <= mem_addr_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command sequencer; reset drops any operation in flight
	// reset aborts
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q  <= nvp_pkg::ST_IDLE;
			cmd_q    <= nvp_pkg::nvp_cmd_e'(nvp_pkg::CMD_RESET);
			cnt_q    <= 8'h00;
			flash_busy_flag_q  <= 1'b0;
			eeprom_busy_flag_q <= 1'b0;
			err_q    <= 1'b0;
			op_o     <= '0;
			fuse_wr_o <= 1'b0;
		end
		else
		begin
			op_o.erase <= 1'b0;
			op_o.write <= 1'b0;
			fuse_wr_o  <= 1'b0;
			case (state_q)
				nvp_pkg::ST_IDLE:
				begin
					if (cmd_wr && !busy)
					begin
						cmd_q <= new_cmd;
						err_q <= 1'b0;
						op_o.region     <= pb_region_q;
						op_o.page_addr  <= addr_q;
						op_o.chip       <= 1'b0;
						op_o.eeprom_all <= 1'b0;
						case (new_cmd)
							nvp_pkg::CMD_WP, nvp_pkg::CMD_ER, nvp_pkg::CMD_ERWP:
							begin
								if (prot_bad)
									err_q <= 1'b1;
								else if (new_cmd != nvp_pkg::CMD_ER || mark_q != '0)
								begin
									flash_busy_flag_q  <= is_flash;
									eeprom_busy_flag_q <= ~is_flash;
									cnt_q    <= nvp_pkg::PROG_CNT;
									state_q  <= (new_cmd == nvp_pkg::CMD_WP) ? nvp_pkg::ST_WRITE : nvp_pkg::ST_ERASE;
								end
							end
							nvp_pkg::CMD_PBC:
							begin
								flash_busy_flag_q <= 1'b1;
								cnt_q   <= nvp_pkg::PBC_CNT;
								state_q <= nvp_pkg::ST_PBC;
							end
							nvp_pkg::CMD_CHER:
							begin
								flash_busy_flag_q         <= 1'b1;
								eeprom_busy_flag_q        <= ~keep_q;
								op_o.chip       <= 1'b1;
								op_o.eeprom_all <= ~keep_q;
								cnt_q           <= nvp_pkg::PROG_CNT;
								state_q         <= nvp_pkg::ST_ERASE;
							end
							nvp_pkg::CMD_EEER:
							begin
								eeprom_busy_flag_q        <= 1'b1;
								flash_busy_flag_q         <= 1'b1;
								op_o.eeprom_all <= 1'b1;
								cnt_q           <= nvp_pkg::PROG_CNT;
								state_q         <= nvp_pkg::ST_ERASE;
							end
							nvp_pkg::CMD_WFU:
							begin
								if (from_debug_i)
									fuse_wr_o <= 1'b1;
								else
									err_q <= 1'b1;
							end
							default:
							begin
								cmd_q <= nvp_pkg::CMD_NONE;
							end
						endcase
					end
				end
				nvp_pkg::ST_ERASE:
				begin
					op_o.erase <= (cnt_q == nvp_pkg::PROG_CNT);
					cnt_q      <= cnt_q - 8'h01;
					if (cnt_q == 8'h01)
					begin
						if (cmd_q == nvp_pkg::CMD_ERWP)
						begin
							cnt_q   <= nvp_pkg::PROG_CNT;
							state_q <= nvp_pkg::ST_WRITE;
						end
						else
						begin
							flash_busy_flag_q  <= 1'b0;
							eeprom_busy_flag_q <= 1'b0;
							state_q  <= nvp_pkg::ST_IDLE;
						end
					end
				end
				nvp_pkg::ST_WRITE:
				begin
					op_o.write <= (cnt_q == nvp_pkg::PROG_CNT);
					cnt_q      <= cnt_q - 8'h01;
					if (cnt_q == 8'h01)
					begin
						flash_busy_flag_q  <= 1'b0;
						eeprom_busy_flag_q <= 1'b0;
						state_q  <= nvp_pkg::ST_IDLE;
					end
				end
				nvp_pkg::ST_PBC:
				begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h01)
					begin
						flash_busy_flag_q <= 1'b0;
						state_q <= nvp_pkg::ST_IDLE;
					end
				end
				default:
				begin
					state_q <= nvp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// buffer clears at end of page op, on clear command, and on wake
	// buffer to ones
	assign clear_pb = wake_i || (state_q != nvp_pkg::ST_IDLE && cnt_q == 8'h01 &&
		!(state_q == nvp_pkg::ST_ERASE && cmd_q == nvp_pkg::CMD_ERWP));

	////////////////////////////////////////////////////////////////////////////
	// page buffer: stores AND into old content and mark the byte
	// and-merge store
	genvar gi;
	generate
		for (gi = 0; gi < nvp_pkg::PB_BYTES; gi++)
		begin : g_pb
			always_ff @(posedge clk_i)
			begin
				if (rst_i || clear_pb)
				begin
					pb_q[gi]   <= 8'hFF;
					mark_q[gi] <= 1'b0;
				end
				else if (mem_req_i && mem_we_i && !busy && mem_addr_i[nvp_pkg::PB_AW-1:0] == 6'(gi))
				begin
					pb_q[gi]   <= pb_q[gi] & mem_wdata_i;
					mark_q[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// region of buffer content; mixing sections sets the mixed flag
	// mixed sections
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clear_pb)
		begin
			pb_region_q <= nvp_pkg::REG_FLASH;
			pb_mixed_q  <= 1'b0;
		end
		else if (mem_req_i && mem_we_i && !busy)
		begin
			pb_region_q <= mem_region_i;
			if (mark_q != '0 && (mem_region_i != pb_region_q ||
				(mem_region_i == nvp_pkg::REG_FLASH && sec_of(mem_addr_i) != sec_of(addr_q))))
				pb_mixed_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pb_rdata_o <= 8'hFF;
			pb_mark_o  <= 1'b0;
		end
		else
		begin
			pb_rdata_o <= pb_q[pb_raddr_i];
			pb_mark_o  <= mark_q[pb_raddr_i] | (pb_region_q == nvp_pkg::REG_FLASH);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cpu loads wait while busy; locked loader reads return zero
	// stall while busy
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mem_ack_o     <= 1'b0;
			mem_rdata_o   <= 8'h00;
			fetch_block_o <= 1'b0;
			cpu_halt_o    <= 1'b0;
		end
		else
		begin
			mem_ack_o     <= mem_req_i && !mem_ack_o && (mem_we_i || !busy);
			mem_rdata_o   <= (lock_q && mem_region_i == nvp_pkg::REG_FLASH &&
				sec_of(mem_addr_i) == nvp_pkg::SEC_LOADER) ? 8'h00 : mem_arr_rdata_i;
			fetch_block_o <= lock_q && exec_sec == nvp_pkg::SEC_LOADER;
			cpu_halt_o    <= flash_busy_flag_q;
		end
	end

	stall_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mem_req_i && !mem_we_i && busy) |=> !mem_ack_o)
		else $error("load acked while busy");
	pbc_seven_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == nvp_pkg::ST_IDLE && cmd_wr && !busy && new_cmd == nvp_pkg::CMD_PBC)
		|=> flash_busy_flag_q [*7] ##1 !flash_busy_flag_q)
		else $error("buffer clear not seven cycles");
	wp_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(wp_q) |-> wp_q)
		else $error("write protect dropped");
	and_merge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mem_req_i && mem_we_i && !busy && !clear_pb) |=>
		pb_q[$past(mem_addr_i[5:0])] == ($past(pb_q[mem_addr_i[5:0]]) & $past(mem_wdata_i)))
		else $error("buffer not and-merged");
	erase_mark_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == nvp_pkg::ST_IDLE && cmd_wr && new_cmd == nvp_pkg::CMD_ER && mark_q == '0)
		|=> state_q == nvp_pkg::ST_IDLE)
		else $error("erase ran with empty buffer");
	prot_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == nvp_pkg::ST_IDLE && cmd_wr && new_cmd == nvp_pkg::CMD_WP && prot_bad)
		|=> (err_q && state_q == nvp_pkg::ST_IDLE))
		else $error("protected write not refused");
	halt_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cpu_halt_o == $past(flash_busy_flag_q))
		else $error("cpu halt not tracking flash busy");
	cov_pbc_c: cover property (@(posedge clk_i) state_q == nvp_pkg::ST_PBC);
	cov_erwp_c: cover property (@(posedge clk_i) state_q == nvp_pkg::ST_ERASE ##[1:200] state_q == nvp_pkg::ST_WRITE);
	cov_err_c: cover property (@(posedge clk_i) err_q);

endmodule

/* File: rtl/nvp_pkg.sv */
// shared constants and types for the nvm page program controller
package nvp_pkg;

	// register byte offsets on the wishbone bus
	localparam logic [3:0] OFS_CTRLA   = 4'h0;
	localparam logic [3:0] OFS_CTRLB   = 4'h4;
	localparam logic [3:0] OFS_STATUS  = 4'h8;
	localparam logic [3:0] OFS_ADDR    = 4'hC;
	// ctrlb field positions
	localparam int         CTRLB_WP_BIT   = 0;
	localparam int         CTRLB_LOCK_BIT = 1;
	// reset values
	localparam logic [2:0] CMD_RESET   = 3'h0;
	// geometry: 64-byte page buffer, 256-byte section granules
	localparam int         PB_BYTES    = 64;
	localparam int         PB_AW       = 6;
	localparam int         GRAN_SHIFT  = 8;
	// array region select on the memory port (mem_region_i)
	localparam logic [1:0] REG_FLASH   = 2'h0;
	localparam logic [1:0] REG_EEPROM  = 2'h1;
	localparam logic [1:0] REG_USERROW = 2'h2;
	// timing in cycles at 25 MHz
	localparam int         CLK_MHZ     = 25;
	localparam int         PBC_CYCLES  = 7;
	localparam int         PROG_NS     = 2000;
	localparam int         PROG_CYCLES = (PROG_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] PROG_CNT    = 8'(PROG_CYCLES);
	localparam logic [7:0] PBC_CNT     = 8'(PBC_CYCLES);

	// command codes
	typedef enum logic [2:0]
	{
		CMD_NONE  = 3'b000,
		CMD_WP    = 3'b001,
		CMD_ER    = 3'b010,
		CMD_ERWP  = 3'b011,
		CMD_PBC   = 3'b100,
		CMD_CHER  = 3'b101,
		CMD_EEER  = 3'b110,
		CMD_WFU   = 3'b111
	} nvp_cmd_e;

	// flash section of an address
	typedef enum logic [1:0]
	{
		SEC_LOADER = 2'b00,
		SEC_CODE   = 2'b01,
		SEC_DATA   = 2'b10
	} nvp_sec_e;

	// controller state
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_ERASE = 2'b01,
		ST_WRITE = 2'b10,
		ST_PBC   = 2'b11
	} nvp_state_e;

	// array write strobe toward the memory macros
	typedef struct packed
	{
		logic        erase;
		logic        write;
		logic        chip;
		logic        eeprom_all;
		logic [1:0]  region;
		logic [15:0] page_addr;
	} nvp_op_s;

endpackage

/* File: verif/nvm_page_program_controller_bench.sv */
// self-checking bench for the nvm page program controller
module nvm_page_program_controller_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic             clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, mem_req, mem_we, mem_ack;
	logic             from_debug, wake, clr, fetch_block, cpu_halt, pb_mark, fuse_wr, chip_seen, fuse_seen;
	logic [3:0]       wb_adr, wb_sel;
	logic [31:0]      wb_wdat, wb_dat, wb_rdat, st;
	logic [1:0]       mem_region;
	logic [15:0]      mem_addr, fetch_addr;
	logic [7:0]       mem_wdata, arr_rdata, mem_rdata, pb_rdata;
	logic [5:0]       pb_raddr;
	nvp_pkg::nvp_op_s op;
	int               n_mismatch, samples_checked, cycles, n_halt, n_er, n_wr;
	logic [15:0]      t_fetch [6] = '{16'h0100, 16'h0500, 16'h0500, 16'h0100, 16'h0900, 16'h0100};
	logic [1:0]       t_reg   [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
	logic [15:0]      t_addr  [6] = '{16'h0410, 16'h0600, 16'h0900, 16'h0010, 16'h0010, 16'h0010};
	logic             t_err   [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

	nvp_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
		.mem_req_i(mem_req), .mem_we_i(mem_we), .mem_region_i(mem_region), .mem_addr_i(mem_addr),
		.mem_wdata_i(mem_wdata), .mem_arr_rdata_i(arr_rdata), .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack),
		.fetch_addr_i(fetch_addr), .from_debug_i(from_debug), .fetch_block_o(fetch_block),
		.cpu_halt_o(cpu_halt), .loader_section_end_fuse_i(8'h04), .code_section_end_fuse_i(8'h08),
		.eeprom_keep_fuse_i(1'b0), .wake_i(wake), .op_o(op), .pb_rdata_o(pb_rdata), .pb_mark_o(pb_mark),
		.pb_raddr_i(pb_raddr), .fuse_wr_o(fuse_wr));

	nvp_array_model u_array (.clk_i(clk_i), .mem_req_i(mem_req), .mem_addr_i(mem_addr), .op_i(op),
		.rdata_o(arr_rdata));

	////////////////////////////////////////////////////////////////////////////////
	// clock and per-command event record, cleared by clr
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (clr)
		begin
			n_halt <= 0;
			n_er <= 0;
			n_wr <= 0;
			chip_seen <= 1'b0;
			fuse_seen <= 1'b0;
		end
		else
		begin
			n_halt <= n_halt + int'(cpu_halt);
			n_er <= n_er + int'(op.erase);
			n_wr <= n_wr + int'(op.write);
			chip_seen <= chip_seen | op.chip;
			fuse_seen <= fuse_seen | fuse_wr;
		end
		// a hang is cut short well above the longest expected run
		if (cycles == 40000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// access tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		wb_rdat = wb_dat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic mem_xfer(input logic w, input logic [1:0] r, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		mem_req <= 1'b1;
		mem_we <= w;
		mem_region <= r;
		mem_addr <= a;
		mem_wdata <= d;
		do @(posedge clk_i); while (mem_ack !== 1'b1);
		mem_req <= 1'b0;
		mem_we <= 1'b0;
	endtask

	task automatic pb_peek(input logic [5:0] a);
		@(posedge clk_i);
		pb_raddr <= a;
		repeat (2) @(posedge clk_i);
	endtask

	// command, then a load that must wait out flash or eeprom busy, then poll to idle
	task automatic do_cmd(input logic [2:0] c);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		wb_xfer(1'b1, nvp_pkg::OFS_CTRLA, {29'h0, c});
		mem_xfer(1'b0, nvp_pkg::REG_FLASH, 16'h0410, 8'h00);
		wb_xfer(1'b0, nvp_pkg::OFS_STATUS, 32'h0);
		st = wb_rdat;
		do wb_xfer(1'b0, nvp_pkg::OFS_STATUS, 32'h0); while (wb_rdat[1:0] !== 2'b00);
	endtask

	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{wb_cyc, wb_stb, wb_we, mem_req, mem_we, from_debug, wake, clr} = '0;
		{wb_adr, wb_wdat, mem_region, mem_addr, mem_wdata, pb_raddr} = '0;
		wb_sel = 4'hF;
		fetch_addr = 16'h0100;
		{cycles, n_mismatch, samples_checked} = '0;
		rst_i = 1'b1;
		do_reset();
		wb_xfer(1'b0, nvp_pkg::OFS_STATUS, 32'h0);
		check(wb_rdat, 32'h0);
		wb_xfer(1'b0, 4'h2, 32'h0);
		check(wb_rdat, 32'h0);
		pb_peek(6'h05);
		check(32'(pb_rdata), 32'hFF);
		$display("test reset done");
		mem_xfer(1'b1, nvp_pkg::REG_EEPROM, 16'h0005, 8'hA5);
		mem_xfer(1'b1, nvp_pkg::REG_EEPROM, 16'h0005, 8'h3C);
		pb_peek(6'h05);
		check({pb_mark, pb_rdata}, 32'h124);
		pb_peek(6'h06);
		check({pb_mark, pb_rdata}, 32'h0FF);
		do_cmd(nvp_pkg::CMD_PBC);
		check(32'(n_halt), 32'(nvp_pkg::PBC_CYCLES));
		pb_peek(6'h05);
		check({pb_mark, pb_rdata}, 32'h1FF);
		do_cmd(nvp_pkg::CMD_NONE);
		check(32'(n_er + n_wr + n_halt), 32'h0);
		do_cmd(nvp_pkg::CMD_ER);
		check(32'(n_er + n_halt), 32'h0);
		mem_xfer(1'b1, nvp_pkg::REG_EEPROM, 16'h0007, 8'h00);
		do_cmd(nvp_pkg::CMD_ER);
		check({n_er == 1, n_halt == 0}, 32'h3);
		mem_xfer(1'b1, nvp_pkg::REG_FLASH, 16'h0410, 8'h11);
		do_cmd(nvp_pkg::CMD_ERWP);
		check({n_er == 1, n_wr == 1, n_halt != 0}, 32'h7);
		pb_peek(6'h10);
		check(32'(pb_rdata), 32'hFF);
		$display("test buffer done");
		for (int i = 0; i < 6; i++)
		begin
			do_cmd(nvp_pkg::CMD_PBC);
			fetch_addr <= t_fetch[i];
			mem_xfer(1'b1, t_reg[i], t_addr[i], 8'h5A);
			do_cmd(nvp_pkg::CMD_WP);
			check(32'(st[2]), 32'(t_err[i]));
			check(32'(n_halt != 0), 32'(t_reg[i] == 2'h0 && !t_err[i]));
			check(32'(st[0]), 32'h0);
		end
		$display("test sections done");
		fetch_addr <= 16'h0100;
		wb_xfer(1'b1, nvp_pkg::OFS_CTRLB, 32'h1);
		wb_xfer(1'b0, nvp_pkg::OFS_CTRLB, 32'h0);
		check(wb_rdat, 32'h1);
		do_cmd(nvp_pkg::CMD_PBC);
		mem_xfer(1'b1, nvp_pkg::REG_FLASH, 16'h0410, 8'h22);
		do_cmd(nvp_pkg::CMD_WP);
		check({st[2], n_wr == 0}, 32'h3);
		wb_xfer(1'b1, nvp_pkg::OFS_CTRLB, 32'h3);
		fetch_addr <= 16'h0500;
		mem_xfer(1'b0, nvp_pkg::REG_FLASH, 16'h0010, 8'h00);
		check(32'(mem_rdata), 32'h0);
		fetch_addr <= 16'h0100;
		repeat (3) @(posedge clk_i);
		check(32'(fetch_block), 32'h1);
		do_reset();
		wb_xfer(1'b0, nvp_pkg::OFS_CTRLB, 32'h0);
		check(wb_rdat, 32'h0);
		$display("test locks done");
		do_cmd(nvp_pkg::CMD_CHER);
		check(32'(chip_seen), 32'h1);
		check(32'(op.eeprom_all), 32'h1);
		do_cmd(nvp_pkg::CMD_EEER);
		check(32'(n_halt != 0), 32'h1);
		check(32'(op.eeprom_all), 32'h1);
		do_cmd(nvp_pkg::CMD_WFU);
		check(32'(fuse_seen), 32'h0);
		from_debug <= 1'b1;
		wb_xfer(1'b1, nvp_pkg::OFS_ADDR, 32'h1);
		do_cmd(nvp_pkg::CMD_WFU);
		check(32'(fuse_seen), 32'h1);
		from_debug <= 1'b0;
		mem_xfer(1'b1, nvp_pkg::REG_FLASH, 16'h0420, 8'h00);
		wake <= 1'b1;
		@(posedge clk_i);
		wake <= 1'b0;
		pb_peek(6'h20);
		check(32'(pb_rdata), 32'hFF);
		$display("test commands done");
		conclude();
	end
endmodule

/* File: verif/nvp_array_model.sv */
// behavioural flash and eeprom array that feeds load data back to the controller
module nvp_array_model
(
	input  wire logic             clk_i,
	input  wire logic             mem_req_i,
	input  wire logic [15:0]      mem_addr_i,
	input  wire nvp_pkg::nvp_op_s op_i,
	output logic      [7:0]       rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       erased_q = 1'b0;
	logic [7:0] idle_q   = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// an erase leaves ones until the next page write brings a pattern back
	always @(posedge clk_i)
	begin
		if (op_i.erase || op_i.chip)
			erased_q <= 1'b1;
		else if (op_i.write)
			erased_q <= 1'b0;
		idle_q <= ~rdata_o;
	end

	// released bus toggles, so a stale byte is never taken for data
	assign rdata_o = !mem_req_i ? idle_q : (erased_q ? 8'hFF : mem_addr_i[7:0] ^ 8'h5A);
endmodule
